// >>> design/wwdg_pkg.sv
package wwdg_pkg;

  // Byte addresses of the word registers on the bus
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WINDOW = 8'h04;
  localparam logic [7:0] ADDR_TMIN   = 8'h08;
  localparam logic [7:0] ADDR_TMAX   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Field layout and reset values
  localparam int          ACT_BIT      = 7;
  localparam int          TOP_BIT      = 6;
  localparam logic [6:0]  COUNT_RESET  = 7'h7F;
  localparam logic [6:0]  WINDOW_RESET = 7'h7F;
  localparam logic [6:0]  ROLL_FROM    = 7'h40;
  localparam int          ST_SLOW      = 0;
  localparam int          ST_WAIT      = 1;
  localparam int          ST_HWOPT     = 2;
  localparam int          ST_ENABLED   = 3;
  localparam int          ST_STATE_LO  = 4;
  localparam int          ST_STATE_HI  = 6;

  // Timing, the oscillator runs on clk
  localparam int OSC_PERIOD_NS   = 100;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int STEP_OSC        = 16384;
  localparam int STEP_CYCLES     = (STEP_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_SHORT_CPU  = 256;
  localparam int WAKE_LONG_CPU   = 4096;
  localparam int CPU_PERIOD_NS   = 100;
  localparam int WAKE_SHORT_CYC  = (WAKE_SHORT_CPU * CPU_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int WAKE_LONG_CYC   = (WAKE_LONG_CPU * CPU_PERIOD_NS) / CLK_PERIOD_NS;

  // Timeout formula constants, in oscillator periods
  localparam logic [23:0] TMIN_OFFSET = 24'h00_0080;
  localparam logic [23:0] TMIN_MUL    = 24'h00_0040;
  localparam logic [23:0] STEP_LEN    = 24'h00_4000;
  localparam logic [23:0] CORR_OFFSET = 24'h00_00C0;
  localparam logic [23:0] TMAX0       = 24'h00_4000;

  typedef enum logic [2:0] {
    WWDG_BOOT     = 3'b000,
    WWDG_RUN      = 3'b001,
    WWDG_HALT_ONE = 3'b010,
    WWDG_FROZEN   = 3'b011,
    WWDG_ACT_HALT = 3'b100,
    WWDG_WAKE     = 3'b101
  } wwdg_state_t;

  // Upper and lower timebase constants by selection
  function automatic logic [5:0] tb_upper(input logic [1:0] sel);
    case (sel)
      2'b00:   tb_upper = 6'h04;
      2'b01:   tb_upper = 6'h08;
      2'b10:   tb_upper = 6'h14;
      default: tb_upper = 6'h31;
    endcase
  endfunction

  function automatic logic [5:0] tb_lower(input logic [1:0] sel);
    case (sel)
      2'b00:   tb_lower = 6'h3B;
      2'b01:   tb_lower = 6'h35;
      2'b10:   tb_lower = 6'h23;
      default: tb_lower = 6'h36;
    endcase
  endfunction

endpackage

// >>> design/wwdg_top.sv
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - Minimum timeout from base plus corrected steps
// - Maximum timeout from 16384 base plus steps
// - Timebase selection picks the constant pair
// - Count value is counter bits five to zero
// - All divisions truncate downward, except STEP_CYCLES, which rounds up
// - Slow mode leaves counting unchanged
// - Wait mode leaves counting unchanged
// - Plain halt decrements once then freezes
// - Interrupt wake resumes after 256/4096 clocks
// - Reset after halt leaves watchdog disabled
// - Halt with reset option gives reset
// - Active-halt stops counter, interrupt restarts immediately
// - Reset ending active-halt delays counting
// - Hardware option keeps watchdog always active
// - Decrement every 16384 oscillator cycles
// - Roll from 40h to 3Fh resets
// - Reload above window value resets
// - Activation bit sticky until reset
module wwdg_top #(
  parameter int STEP_CNT = wwdg_pkg::STEP_CYCLES  // Clocks per decrement
) (
  input  wire logic        clk,                    // 10 MHz clock
  input  wire logic        sys_rst,                // Async reset, high
  input  wire logic        hsel,                   // AHB select
  input  wire logic [31:0] haddr,                  // AHB address
  input  wire logic [1:0]  htrans,                 // AHB transfer type
  input  wire logic        hwrite,                 // AHB write
  input  wire logic [2:0]  hsize,                  // AHB size
  input  wire logic [31:0] hwdata,                 // AHB write data
  input  wire logic        hready,                 // AHB bus ready
  output logic      [31:0] hrdata,                 // AHB read data
  output logic             hreadyout,              // AHB slave ready
  output logic             hresp,                  // AHB response
  input  wire logic [1:0]  timebase_select,        // Clock controller timebase
  input  wire logic        oscillator_irq_enable,  // Oscillator interrupt enable
  input  wire logic        halt_reset_option,      // Reset on halt option
  input  wire logic        hw_watchdog_option,     // Hardware watchdog option
  input  wire logic        slow_mode,              // CPU in slow mode
  input  wire logic        wait_mode,              // CPU in wait mode
  input  wire logic        halt_exec,              // Halt instruction pulse
  input  wire logic        ext_irq,                // External interrupt
  input  wire logic        osc_irq,                // Oscillator interrupt
  input  wire logic        wake_long,              // Long wake delay selected
  input  wire logic        active_halt_reset,      // Reset ended active-halt
  output logic             watchdog_reset          // Reset request pulse
);

  localparam int PW = $clog2(STEP_CNT);
  localparam int WW = $clog2(wwdg_pkg::WAKE_LONG_CYC + 1);
  localparam logic [PW-1:0] STEP_LAST  = PW'(STEP_CNT - 1);
  localparam logic [WW-1:0] WAKE_SHORT = WW'(wwdg_pkg::WAKE_SHORT_CYC - 1);
  localparam logic [WW-1:0] WAKE_LONG  = WW'(wwdg_pkg::WAKE_LONG_CYC - 1);

  logic [6:0]             timeout_count;
  logic                   watchdog_activation_bit;
  logic [6:0]             watchdog_window_reg;
  logic [PW-1:0]          prescale;
  logic [WW-1:0]          wake_cnt;
  wwdg_pkg::wwdg_state_t  state;
  wwdg_pkg::wwdg_state_t  next_state;
  logic                   tick;
  logic                   enabled;
  logic                   counting;
  logic                   dphase;
  logic                   dwrite;
  logic [7:0]             daddr;
  logic                   ctrl_wr;
  logic                   win_wr;
  logic                   roll_reset;
  logic                   reload_reset;
  logic                   halt_reset;
  logic [23:0]            tmin;
  logic [23:0]            tmax;

  // Bus slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dphase <= 1'b0;
      dwrite <= 1'b0;
      daddr  <= 8'h00;
    end else if (hready) begin
      dphase <= hsel & htrans[1];
      dwrite <= hwrite;
      daddr  <= haddr[7:0];
    end
  end

  assign ctrl_wr = dphase & dwrite & (daddr == wwdg_pkg::ADDR_CTRL);
  assign win_wr  = dphase & dwrite & (daddr == wwdg_pkg::ADDR_WINDOW);

  // Read mux over flop state and live mode and timebase inputs; unmapped reads return zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dphase & ~dwrite) begin
      case (daddr)
        wwdg_pkg::ADDR_CTRL:   hrdata = {24'h00_0000, watchdog_activation_bit, timeout_count};
        wwdg_pkg::ADDR_WINDOW: hrdata = {25'h000_0000, watchdog_window_reg};
        wwdg_pkg::ADDR_TMIN:   hrdata = {8'h00, tmin};
        wwdg_pkg::ADDR_TMAX:   hrdata = {8'h00, tmax};
        wwdg_pkg::ADDR_STATUS: begin
          hrdata[wwdg_pkg::ST_SLOW]    = slow_mode;
          hrdata[wwdg_pkg::ST_WAIT]    = wait_mode;
          hrdata[wwdg_pkg::ST_HWOPT]   = hw_watchdog_option;
          hrdata[wwdg_pkg::ST_ENABLED] = enabled;
          hrdata[wwdg_pkg::ST_STATE_HI:wwdg_pkg::ST_STATE_LO] = state;
        end
        default:               hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Activation can only be set by software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_activation_bit <= 1'b0;
    end else if (ctrl_wr && hwdata[wwdg_pkg::ACT_BIT]) begin
      watchdog_activation_bit <= 1'b1;
    end
  end

  assign enabled = hw_watchdog_option | watchdog_activation_bit;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_window_reg <= wwdg_pkg::WINDOW_RESET;
    end else if (win_wr) begin
      watchdog_window_reg <= hwdata[6:0];
    end
  end

  // Prescaler never restarts on reload, hence the min/max spread
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale <= '0;
    end else if (prescale == STEP_LAST) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + PW'(1);
    end
  end

  assign tick = (prescale == STEP_LAST);

  // Slow and wait modes do not enter this term
  assign counting = (state == wwdg_pkg::WWDG_RUN) |
                    (state == wwdg_pkg::WWDG_HALT_ONE);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_count <= wwdg_pkg::COUNT_RESET;
    end else if (ctrl_wr) begin
      timeout_count <= hwdata[6:0];
    end else if (tick && counting) begin
      timeout_count <= timeout_count - 7'h01;
    end
  end

  // Low-power sequencing
  always_comb begin
    next_state = state;
    case (state)
      wwdg_pkg::WWDG_BOOT: begin
        next_state = active_halt_reset ? wwdg_pkg::WWDG_WAKE
                                       : wwdg_pkg::WWDG_RUN;
      end
      wwdg_pkg::WWDG_RUN: begin
        if (halt_exec && oscillator_irq_enable) begin
          next_state = wwdg_pkg::WWDG_ACT_HALT;
        end else if (halt_exec && !halt_reset_option) begin
          next_state = wwdg_pkg::WWDG_HALT_ONE;
        end
      end
      wwdg_pkg::WWDG_HALT_ONE: begin
        if (ext_irq) begin
          next_state = wwdg_pkg::WWDG_WAKE;
        end else if (tick) begin
          next_state = wwdg_pkg::WWDG_FROZEN;
        end
      end
      wwdg_pkg::WWDG_FROZEN: begin
        if (ext_irq) begin
          next_state = wwdg_pkg::WWDG_WAKE;
        end
      end
      wwdg_pkg::WWDG_ACT_HALT: begin
        if (ext_irq || osc_irq) begin
          next_state = wwdg_pkg::WWDG_RUN;
        end
      end
      wwdg_pkg::WWDG_WAKE: begin
        if (wake_cnt == '0) begin
          next_state = wwdg_pkg::WWDG_RUN;
        end
      end
      default: next_state = wwdg_pkg::WWDG_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= wwdg_pkg::WWDG_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // Wake delay loaded on entry, length sampled then
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_cnt <= '0;
    end else if (next_state == wwdg_pkg::WWDG_WAKE && state != wwdg_pkg::WWDG_WAKE) begin
      wake_cnt <= wake_long ? WAKE_LONG : WAKE_SHORT;
    end else if (wake_cnt != '0) begin
      wake_cnt <= wake_cnt - WW'(1);
    end
  end

  // Reset sources; in halt states no watchdog reset can arise
  assign roll_reset   = enabled && (state == wwdg_pkg::WWDG_RUN) &&
                        ((tick && !ctrl_wr && timeout_count == wwdg_pkg::ROLL_FROM) ||
                         (ctrl_wr && !hwdata[wwdg_pkg::TOP_BIT]));
  assign reload_reset = enabled && (state == wwdg_pkg::WWDG_RUN) && ctrl_wr &&
                        (timeout_count > watchdog_window_reg);
  assign halt_reset   = (state == wwdg_pkg::WWDG_RUN) && halt_exec &&
                        !oscillator_irq_enable && halt_reset_option;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= roll_reset | reload_reset | halt_reset;
    end
  end

  // Exact timeout figures for the current count and timebase
  always_comb begin
    logic [5:0]  cnt;
    logic [5:0]  upper;
    logic [5:0]  lower;
    logic [5:0]  q;
    logic [5:0]  quarter;
    logic [23:0] bracket;
    cnt     = timeout_count[5:0];
    upper   = wwdg_pkg::tb_upper(timebase_select);
    lower   = wwdg_pkg::tb_lower(timebase_select);
    quarter = upper >> 2;
    q       = 6'({2'b00, cnt, 2'b00} / {2'b00, upper});
    bracket = wwdg_pkg::STEP_LEN * 24'(cnt - q) +
              (wwdg_pkg::CORR_OFFSET + 24'(lower)) * wwdg_pkg::TMIN_MUL * 24'(q);
    tmin = (24'(lower) + wwdg_pkg::TMIN_OFFSET) * wwdg_pkg::TMIN_MUL;
    if (cnt < quarter) begin
      tmin = tmin + wwdg_pkg::STEP_LEN * 24'(cnt);
    end else begin
      tmin = tmin + bracket;
    end
    if (cnt <= quarter) begin
      tmax = wwdg_pkg::TMAX0 + wwdg_pkg::STEP_LEN * 24'(cnt);
    end else begin
      tmax = wwdg_pkg::TMAX0 + bracket;
    end
  end

  // Assertion helper: cycles spent so far in the current wake delay
  logic [WW-1:0] wake_seen;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_seen <= '0;
    end else if (state == wwdg_pkg::WWDG_WAKE) begin
      wake_seen <= wake_seen + WW'(1);
    end else begin
      wake_seen <= '0;
    end
  end

  // Checks
  roll_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
    (enabled && state == wwdg_pkg::WWDG_RUN && tick && !ctrl_wr &&
     timeout_count == wwdg_pkg::ROLL_FROM) |=> watchdog_reset)
    else $error("No reset on roll from 40h");

  window_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    (enabled && state == wwdg_pkg::WWDG_RUN && ctrl_wr &&
     timeout_count > watchdog_window_reg) |=> watchdog_reset)
    else $error("Early reload did not reset");

  sticky_act_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(watchdog_activation_bit) |-> watchdog_activation_bit)
    else $error("Activation bit cleared without reset");

  // Activation bit clear, so only the option can make this roll reset
  hw_active_a: assert property (@(posedge clk) disable iff (sys_rst)
    (hw_watchdog_option && !watchdog_activation_bit && state == wwdg_pkg::WWDG_RUN &&
     tick && !ctrl_wr && timeout_count == wwdg_pkg::ROLL_FROM) |=> watchdog_reset)
    else $error("Hardware option not active");

  step_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!ctrl_wr && !tick) |=> timeout_count == $past(timeout_count))
    else $error("Counter moved between steps");

  frozen_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == wwdg_pkg::WWDG_FROZEN && !ctrl_wr) |=>
      (timeout_count == $past(timeout_count) && !watchdog_reset))
    else $error("Counter moved while frozen");

  halt_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == wwdg_pkg::WWDG_HALT_ONE && tick && !ext_irq && !ctrl_wr) |=>
      (state == wwdg_pkg::WWDG_FROZEN && timeout_count == $past(timeout_count) - 7'h01))
    else $error("Halt did not take its single step");

  lp_no_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state != wwdg_pkg::WWDG_RUN) |=> !watchdog_reset)
    else $error("Reset raised outside run");

  act_halt_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == wwdg_pkg::WWDG_ACT_HALT && (ext_irq || osc_irq)) |=>
      state == wwdg_pkg::WWDG_RUN)
    else $error("Active-halt did not wake at once");

  halt_opt_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == wwdg_pkg::WWDG_RUN && halt_exec && !oscillator_irq_enable &&
     halt_reset_option) |=> (watchdog_reset && state == wwdg_pkg::WWDG_RUN))
    else $error("Halt with option did not reset");

  // First and last short wake cycles pinned; the counter covers the span
  wake_short_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == wwdg_pkg::WWDG_FROZEN && ext_irq && !wake_long) |=>
      state == wwdg_pkg::WWDG_WAKE ##255 state == wwdg_pkg::WWDG_WAKE ##1
      state == wwdg_pkg::WWDG_RUN)
    else $error("Short wake delay wrong");

  wake_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == wwdg_pkg::WWDG_WAKE && next_state != wwdg_pkg::WWDG_WAKE) |->
      (wake_seen == WAKE_SHORT || wake_seen == WAKE_LONG))
    else $error("Wake delay ended at wrong count");

  wake_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == wwdg_pkg::WWDG_WAKE) |-> (wake_seen <= WAKE_LONG))
    else $error("Wake delay overran");

  tmax_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    (timeout_count[5:0] == 6'h00) |->
      (tmax == wwdg_pkg::TMAX0 && tmin == (24'(wwdg_pkg::tb_lower(timebase_select)) +
       wwdg_pkg::TMIN_OFFSET) * wwdg_pkg::TMIN_MUL))
    else $error("Zero-count timeouts wrong");

endmodule

// >>> testbench/window_watchdog_timeout_lowpower_bench.sv
`timescale 1ns/100ps
module window_watchdog_timeout_lowpower_bench;
  logic        clk                   = 1'b0;
  logic        sys_rst               = 1'b1;
  logic        hsel                  = 1'b0;
  logic [31:0] haddr                 = 32'h0000_0000;
  logic [1:0]  htrans                = 2'b00;
  logic        hwrite                = 1'b0;
  logic [2:0]  hsize                 = 3'b010;
  logic [31:0] hwdata                = 32'h0000_0000;
  logic [1:0]  timebase_select       = 2'b00;
  logic        oscillator_irq_enable = 1'b0;
  logic        halt_reset_option     = 1'b0;
  logic        hw_watchdog_option    = 1'b0;
  logic        slow_mode             = 1'b0;
  logic        wait_mode             = 1'b0;
  logic        halt_exec             = 1'b0;
  logic        ext_irq               = 1'b0;
  logic        osc_irq               = 1'b0;
  logic        wake_long             = 1'b0;
  logic        active_halt_reset     = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        watchdog_reset;
  wire         hready                = hreadyout;  // Single slave drives bus ready
  logic [31:0] rd_q;
  logic [31:0] c0;
  logic [31:0] c1;
  logic [31:0] c2;
  logic [31:0] tmn;
  logic [31:0] tmx;
  int          mismatches            = 0;
  int          checks_done           = 0;
  int          pulses                = 0;
  int          pbase                 = 0;
  int          n;
  int          cv[5]                 = '{1, 2, 5, 12, 63};

  wwdg_top #(.STEP_CNT(16)) u_dut (
    .clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .timebase_select, .oscillator_irq_enable,
    .halt_reset_option, .hw_watchdog_option, .slow_mode, .wait_mode, .halt_exec,
    .ext_irq, .osc_irq, .wake_long, .active_halt_reset, .watchdog_reset
  );

  always #50 clk = ~clk;

  // Capture at the edge itself, so no race with the design's own updates
  always @(posedge clk) begin
    rd_q <= hrdata;
    if (watchdog_reset === 1'b1) pulses <= pulses + 1;
  end

  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      $display("Error at %0t: bus hang", $time);
      end_sim();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    @(negedge clk);
    r = rd_q;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0000_0000, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    chk(r, exp);
  endtask

  task automatic st_chk(input logic [2:0] s, input logic en);
    rchk(wwdg_pkg::ADDR_STATUS,
         {25'h000_0000, s, en, hw_watchdog_option, wait_mode, slow_mode});
  endtask

  task automatic pchk(input int k);
    chk(pulses - pbase, k);
    pbase = pulses;
  endtask

  // Two counter samples exactly 64 clocks, four ticks, apart
  task automatic drift(output logic [31:0] a, output logic [31:0] b);
    rd(wwdg_pkg::ADDR_CTRL, a);
    repeat (61) @(posedge clk);
    rd(wwdg_pkg::ADDR_CTRL, b);
  endtask

  task automatic kick(input int k);
    @(posedge clk);
    halt_exec <= (k == 0);
    ext_irq <= (k == 1);
    osc_irq <= (k == 2);
    @(posedge clk);
    {halt_exec, ext_irq, osc_irq} <= 3'b000;
  endtask

  task automatic do_rst(input logic ahr);
    @(posedge clk);
    sys_rst <= 1'b1;
    active_halt_reset <= ahr;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    active_halt_reset <= 1'b0;
    pbase = pulses;
  endtask

  function automatic logic [31:0] tmo(input logic [1:0] sel, input logic [5:0] cnt,
                                      input logic mx);
    int u;
    int l;
    int q;
    int b;
    u = (sel == 2'b00) ? 4 : (sel == 2'b01) ? 8 : (sel == 2'b10) ? 20 : 49;
    l = (sel == 2'b00) ? 59 : (sel == 2'b01) ? 53 : (sel == 2'b10) ? 35 : 54;
    q = 4 * int'(cnt) / u;
    b = mx ? 16384 : (l + 128) * 64;
    if (mx ? (int'(cnt) <= u / 4) : (int'(cnt) < u / 4)) tmo = b + 16384 * int'(cnt);
    else tmo = b + 16384 * (int'(cnt) - q) + (192 + l) * 64 * q;
  endfunction

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    $display("Error at %0t: run timeout", $time);
    end_sim();
  end

  initial begin
    do_rst(1'b0);
    rchk(wwdg_pkg::ADDR_CTRL, 32'h0000_007F);
    rchk(wwdg_pkg::ADDR_WINDOW, 32'h0000_007F);
    st_chk(3'd1, 1'b0);
    @(posedge clk);
    slow_mode <= 1'b1;
    wait_mode <= 1'b1;
    wr(wwdg_pkg::ADDR_CTRL, 32'h0000_007F);
    drift(c0, c1);
    chk(c1, c0 - 4);
    st_chk(3'd1, 1'b0);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) timebase_select <= s[1:0];
      for (int i = 0; i < 5; i++) begin
        wr(wwdg_pkg::ADDR_CTRL, 32'h0000_0040 | 32'(cv[i]));
        n = 0;
        // Retry when a tick lands between the samples
        do begin
          rd(wwdg_pkg::ADDR_CTRL, c0);
          rd(wwdg_pkg::ADDR_TMIN, tmn);
          rd(wwdg_pkg::ADDR_TMAX, tmx);
          rd(wwdg_pkg::ADDR_CTRL, c1);
          n++;
        end while (c0 !== c1 && n < 4);
        chk(tmn, tmo(s[1:0], c0[5:0], 1'b0));
        chk(tmx, tmo(s[1:0], c0[5:0], 1'b1));
      end
    end
    wr(wwdg_pkg::ADDR_CTRL, 32'h0000_00C1);
    wr(wwdg_pkg::ADDR_CTRL, 32'h0000_0041);
    rd(wwdg_pkg::ADDR_CTRL, c0);
    chk(c0[7], 1'b1);
    st_chk(3'd1, 1'b1);
    repeat (40) @(posedge clk);
    pchk(1);
    do_rst(1'b0);
    st_chk(3'd1, 1'b0);
    wr(wwdg_pkg::ADDR_CTRL, 32'h0000_00C5);
    wr(wwdg_pkg::ADDR_WINDOW, 32'h0000_0042);
    rchk(wwdg_pkg::ADDR_WINDOW, 32'h0000_0042);
    wr(wwdg_pkg::ADDR_CTRL, 32'h0000_00C5);
    repeat (3) @(posedge clk);
    pchk(1);
    @(posedge clk) hw_watchdog_option <= 1'b1;
    do_rst(1'b0);
    st_chk(3'd1, 1'b1);
    wr(wwdg_pkg::ADDR_CTRL, 32'h0000_0041);
    repeat (40) @(posedge clk);
    pchk(1);
    @(posedge clk) hw_watchdog_option <= 1'b0;
    do_rst(1'b0);
    @(posedge clk) halt_reset_option <= 1'b1;
    kick(0);
    repeat (3) @(posedge clk);
    pchk(1);
    st_chk(3'd1, 1'b0);
    @(posedge clk) halt_reset_option <= 1'b0;
    oscillator_irq_enable <= 1'b1;
    wr(wwdg_pkg::ADDR_CTRL, 32'h0000_007F);
    kick(0);
    st_chk(3'd4, 1'b0);
    drift(c0, c1);
    chk(c1, c0);
    kick(2);
    st_chk(3'd1, 1'b0);
    drift(c0, c1);
    chk(c1, c0 - 4);
    @(posedge clk) oscillator_irq_enable <= 1'b0;
    for (int w = 0; w < 2; w++) begin
      @(posedge clk) wake_long <= w[0];
      wr(wwdg_pkg::ADDR_CTRL, 32'h0000_007F);
      rd(wwdg_pkg::ADDR_CTRL, c0);
      kick(0);
      repeat (40) @(posedge clk);
      st_chk(3'd3, 1'b0);
      drift(c1, c2);
      chk(c2, c1);
      // A normal tick may fall just before the halt is taken
      chk(32'(c0 - c1 - 1) < 2, 1'b1);
      pchk(0);
      kick(1);
      repeat ((w == 1 ? 4096 : 256) - 20) @(posedge clk);
      st_chk(3'd5, 1'b0);
      repeat (30) @(posedge clk);
      st_chk(3'd1, 1'b0);
    end
    @(posedge clk) wake_long <= 1'b0;
    do_rst(1'b1);
    repeat (200) @(posedge clk);
    st_chk(3'd5, 1'b0);
    repeat (60) @(posedge clk);
    st_chk(3'd1, 1'b0);
    end_sim();
  end
endmodule
